// [jpdlc_pkg.sv]
// constants shared by the scan-link debug access controller
// assumes nothing beyond a SystemVerilog-2012 compiler
package jpdlc_pkg;

   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int DATA_W  = 8;
   localparam int FRAME_W = 9;
   localparam int PAR_POS = 8;
   localparam logic [3:0] FRAME_LAST = 4'h8;

   // ----------------------------------------------------------------
   // marker characters, all sent with parity inverted
   // ----------------------------------------------------------------
   localparam logic [7:0] CHR_ABORT = 8'hbb;
   localparam logic [7:0] CHR_WAIT  = 8'hdb;
   localparam logic [7:0] CHR_IDLE  = 8'heb;

   // ----------------------------------------------------------------
   // unlock key
   // ----------------------------------------------------------------
   localparam int KEY_W = 64;
   localparam logic [63:0] UNLOCK_KEY = 64'h1289ab45cdd888ff;
   localparam logic [3:0]  KEY_BYTES  = 4'h8;

   // ----------------------------------------------------------------
   // scan instruction register
   // ----------------------------------------------------------------
   localparam int IR_W = 4;
   localparam logic [3:0] IR_CAPTURE = 4'h1;
   localparam logic [3:0] IR_RESET   = 4'hf;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
      TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
      TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
   } jpdlc_tap_e;

   typedef enum logic [1:0] {
      LM_OFF, LM_NATIVE, LM_SCAN
   } jpdlc_mode_e;

endpackage : jpdlc_pkg

// [jpdlc_top.sv]
// scan-link physical layer and access controller for program/debug
// assumes: tck/tms/tdi come from the programmer; native-link phy event
// inputs are already synchronous to mclk; enable pins are asynchronous
//
// Functional notes
// RULE_01: marker characters carry inverted parity
// RULE_02: abort character 0xbb resets controller state
// RULE_03: wait character 0xdb means no data ready
// RULE_04: idle marker 0xeb means receive mode
// RULE_05: only one direction active at a time
// RULE_06: drive on falling tck, sample rising
// RULE_07: transmit loads byte, appends parity, shifts out
// RULE_08: pending byte at capture sent with parity
// RULE_09: receive mode captures idle marker, parity set
// RULE_10: transmit without byte captures wait marker
// RULE_11: programmer keeps clocking after wait, no resend
// RULE_12: shift nine bits in, latch at update
// RULE_13: check even parity in both modes
// RULE_14: parity error plus 0xbb flags abort
// RULE_15: mode entry initialises; native link wins
// RULE_16: programmer disables old layer before new
// RULE_17: block memory access until key unlocks
// RULE_18: 64-bit key must equal fixed value
// RULE_19: memory access needs controller enabled, programming
// RULE_20: receive exceptions per link type
// RULE_21: transmit exceptions per link type
// RULE_22: exception enters error until abort received
// RULE_23: error state drops frames, no bus access
// RULE_24: link-select instruction picks 9-bit register
// RULE_25: frame is eight bits lsb first, parity
`timescale 1ns/1ps
`default_nettype none

// --------------------------------------------------------------------
// two-flop synchroniser
// --------------------------------------------------------------------
module jpdlc_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_reg <= '0;
         q        <= '0;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : jpdlc_sync2

// --------------------------------------------------------------------
// top
// --------------------------------------------------------------------
module jpdlc_top #(
   parameter logic [3:0] LINK_SEL_CODE = 4'h7
) (
   // system
   input  wire logic       mclk,
   input  wire logic       arst_n,
   // scan port
   input  wire logic       tck,
   input  wire logic       tms,
   input  wire logic       tdi,
   output logic            tdo,
   output logic            tdo_oe,
   // link enables (asynchronous pins)
   input  wire logic       scan_port_enable,
   input  wire logic       native_link_enable,
   // native phy events, mclk domain
   input  wire logic       native_rx_valid,
   input  wire logic [7:0] native_rx_data,
   input  wire logic       native_parity_err,
   input  wire logic       native_frame_err,
   input  wire logic       native_abort,
   input  wire logic       native_collision,
   // command decoder side
   input  wire logic       tx_mode_req,
   input  wire logic       rx_mode_req,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   input  wire logic       key_capture,
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   output logic            abort_seen,
   // status
   output logic            link_error,
   output logic            tx_mode,
   output logic            native_selected,
   output logic            scan_selected,
   output logic            nvm_unlocked,
   // internal access bus gate
   input  wire logic       bus_req,
   input  wire logic       bus_nvm,
   input  wire logic       nvm_ctrl_enabled,
   input  wire logic       nvm_prog_mode,
   output logic            bus_req_out,
   output logic            bus_nvm_out,
   output logic            bus_refused
);

   // -----------------------------------------------------------------
   // tck domain: tap controller
   // -----------------------------------------------------------------
   jpdlc_pkg::jpdlc_tap_e tap_reg;
   jpdlc_pkg::jpdlc_tap_e tap_next;
   logic [jpdlc_pkg::IR_W-1:0]    ir_sr_reg;
   logic [jpdlc_pkg::IR_W-1:0]    ir_reg;
   logic [jpdlc_pkg::FRAME_W-1:0] dr_sr_reg;
   logic                          byp_reg;
   logic [3:0]                    bit_cnt_reg;
   logic                          t_rx_tgl_reg;
   logic [7:0]                    t_rx_data_reg;
   logic                          t_rx_perr_reg;
   logic                          t_rx_abort_reg;
   logic                          t_ack_tgl_reg;
   logic                          t_txm;
   logic                          t_req_tgl;
   logic                          link_sel;
   logic                          t_pend;
   logic                          rx_par_ok;

   always_comb
   begin
      tap_next = tap_reg;
      unique case (tap_reg)
         jpdlc_pkg::TAP_RESET:    tap_next = tms ? jpdlc_pkg::TAP_RESET  : jpdlc_pkg::TAP_IDLE;
         jpdlc_pkg::TAP_IDLE:     tap_next = tms ? jpdlc_pkg::TAP_SEL_DR : jpdlc_pkg::TAP_IDLE;
         jpdlc_pkg::TAP_SEL_DR:   tap_next = tms ? jpdlc_pkg::TAP_SEL_IR : jpdlc_pkg::TAP_CAP_DR;
         jpdlc_pkg::TAP_CAP_DR:   tap_next = tms ? jpdlc_pkg::TAP_EXIT1_DR : jpdlc_pkg::TAP_SHIFT_DR;
         jpdlc_pkg::TAP_SHIFT_DR: tap_next = tms ? jpdlc_pkg::TAP_EXIT1_DR : jpdlc_pkg::TAP_SHIFT_DR;
         jpdlc_pkg::TAP_EXIT1_DR: tap_next = tms ? jpdlc_pkg::TAP_UPD_DR : jpdlc_pkg::TAP_PAUSE_DR;
         jpdlc_pkg::TAP_PAUSE_DR: tap_next = tms ? jpdlc_pkg::TAP_EXIT2_DR : jpdlc_pkg::TAP_PAUSE_DR;
         jpdlc_pkg::TAP_EXIT2_DR: tap_next = tms ? jpdlc_pkg::TAP_UPD_DR : jpdlc_pkg::TAP_SHIFT_DR;
         jpdlc_pkg::TAP_UPD_DR:   tap_next = tms ? jpdlc_pkg::TAP_SEL_DR : jpdlc_pkg::TAP_IDLE;
         jpdlc_pkg::TAP_SEL_IR:   tap_next = tms ? jpdlc_pkg::TAP_RESET  : jpdlc_pkg::TAP_CAP_IR;
         jpdlc_pkg::TAP_CAP_IR:   tap_next = tms ? jpdlc_pkg::TAP_EXIT1_IR : jpdlc_pkg::TAP_SHIFT_IR;
         jpdlc_pkg::TAP_SHIFT_IR: tap_next = tms ? jpdlc_pkg::TAP_EXIT1_IR : jpdlc_pkg::TAP_SHIFT_IR;
         jpdlc_pkg::TAP_EXIT1_IR: tap_next = tms ? jpdlc_pkg::TAP_UPD_IR : jpdlc_pkg::TAP_PAUSE_IR;
         jpdlc_pkg::TAP_PAUSE_IR: tap_next = tms ? jpdlc_pkg::TAP_EXIT2_IR : jpdlc_pkg::TAP_PAUSE_IR;
         jpdlc_pkg::TAP_EXIT2_IR: tap_next = tms ? jpdlc_pkg::TAP_UPD_IR : jpdlc_pkg::TAP_SHIFT_IR;
         jpdlc_pkg::TAP_UPD_IR:   tap_next = tms ? jpdlc_pkg::TAP_SEL_DR : jpdlc_pkg::TAP_IDLE;
      endcase
   end

   always_ff @(posedge tck or negedge arst_n)
   begin
      if (!arst_n)
         tap_reg <= jpdlc_pkg::TAP_RESET;
      else
         tap_reg <= tap_next;
   end

   // instruction register; test-logic-reset falls back to bypass
   always_ff @(posedge tck or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ir_sr_reg <= jpdlc_pkg::IR_CAPTURE;
         ir_reg    <= jpdlc_pkg::IR_RESET;
      end
      else
      begin
         unique case (tap_reg)
            jpdlc_pkg::TAP_RESET:    ir_reg    <= jpdlc_pkg::IR_RESET;
            jpdlc_pkg::TAP_CAP_IR:   ir_sr_reg <= jpdlc_pkg::IR_CAPTURE;
            jpdlc_pkg::TAP_SHIFT_IR: ir_sr_reg <= {tdi, ir_sr_reg[jpdlc_pkg::IR_W-1:1]};
            jpdlc_pkg::TAP_UPD_IR:   ir_reg    <= ir_sr_reg;
            default:                 ir_reg    <= ir_reg;
         endcase
      end
   end

   assign link_sel  = (ir_reg == LINK_SEL_CODE); // RULE_24
   assign t_pend    = (t_req_tgl != t_ack_tgl_reg);
   assign rx_par_ok = ((^dr_sr_reg[jpdlc_pkg::DATA_W-1:0]) == dr_sr_reg[jpdlc_pkg::PAR_POS]);

   // -----------------------------------------------------------------
   // tck domain: 9-bit communication register
   // -----------------------------------------------------------------
   // tx byte from mclk is stable while the request toggle is unanswered
   always_ff @(posedge tck or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dr_sr_reg     <= '0;
         byp_reg       <= 1'b0;
         bit_cnt_reg   <= '0;
         t_ack_tgl_reg <= 1'b0;
      end
      else if (link_sel)
      begin
         if (tap_reg == jpdlc_pkg::TAP_CAP_DR)
         begin
            bit_cnt_reg <= '0;
            if (t_txm && t_pend)
            begin
               dr_sr_reg     <= {^tx_data, tx_data}; // RULE_07 RULE_08
               t_ack_tgl_reg <= ~t_ack_tgl_reg;
            end
            else if (t_txm)
               dr_sr_reg <= {~(^jpdlc_pkg::CHR_WAIT), jpdlc_pkg::CHR_WAIT}; // RULE_10 RULE_03 RULE_01
            else
               dr_sr_reg <= {~(^jpdlc_pkg::CHR_IDLE), jpdlc_pkg::CHR_IDLE}; // RULE_09 RULE_04 RULE_01
         end
         else if (tap_reg == jpdlc_pkg::TAP_SHIFT_DR)
         begin
            // lsb leaves first, tdi enters at the parity end
            dr_sr_reg <= {tdi, dr_sr_reg[jpdlc_pkg::FRAME_W-1:1]}; // RULE_12 RULE_25
            if (bit_cnt_reg != jpdlc_pkg::FRAME_LAST + 4'h1)
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
         end
      end
      else
      begin
         if (tap_reg == jpdlc_pkg::TAP_CAP_DR)
            byp_reg <= 1'b0;
         else if (tap_reg == jpdlc_pkg::TAP_SHIFT_DR)
            byp_reg <= tdi;
      end
   end

   // a frame is handed over only when all nine bits were shifted
   always_ff @(posedge tck or negedge arst_n)
   begin
      if (!arst_n)
      begin
         t_rx_tgl_reg   <= 1'b0;
         t_rx_data_reg  <= '0;
         t_rx_perr_reg  <= 1'b0;
         t_rx_abort_reg <= 1'b0;
      end
      else if (link_sel && tap_reg == jpdlc_pkg::TAP_UPD_DR &&
               bit_cnt_reg > jpdlc_pkg::FRAME_LAST)
      begin
         t_rx_tgl_reg   <= ~t_rx_tgl_reg; // RULE_12
         t_rx_data_reg  <= dr_sr_reg[jpdlc_pkg::DATA_W-1:0];
         t_rx_perr_reg  <= !rx_par_ok; // RULE_13
         t_rx_abort_reg <= !rx_par_ok &&
                           dr_sr_reg[jpdlc_pkg::DATA_W-1:0] == jpdlc_pkg::CHR_ABORT; // RULE_14
      end
   end

   // output changes on the falling edge so the programmer samples on rising
   always_ff @(negedge tck or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tdo    <= 1'b0;
         tdo_oe <= 1'b0;
      end
      else
      begin
         tdo_oe <= (tap_reg == jpdlc_pkg::TAP_SHIFT_DR) ||
                   (tap_reg == jpdlc_pkg::TAP_SHIFT_IR); // RULE_06
         if (tap_reg == jpdlc_pkg::TAP_SHIFT_IR)
            tdo <= ir_sr_reg[0];
         else if (link_sel)
            tdo <= dr_sr_reg[0]; // RULE_06
         else
            tdo <= byp_reg;
      end
   end

   // -----------------------------------------------------------------
   // crossings
   // -----------------------------------------------------------------
   logic tx_mode_reg;
   logic m_req_tgl_reg;
   logic m_rx_tgl;
   logic m_rx_tgl_d_reg;
   logic m_ack_tgl;
   logic m_ack_tgl_d_reg;
   logic m_link_sel;
   logic m_scan_en;
   logic m_native_en;

   jpdlc_sync2 #(.W(2)) u_sync_to_tck (
      .clk   (tck),
      .rst_n (arst_n),
      .d     ({tx_mode_reg, m_req_tgl_reg}),
      .q     ({t_txm, t_req_tgl})
   );

   jpdlc_sync2 #(.W(5)) u_sync_to_mclk (
      .clk   (mclk),
      .rst_n (arst_n),
      .d     ({t_rx_tgl_reg, t_ack_tgl_reg, link_sel, scan_port_enable,
               native_link_enable}),
      .q     ({m_rx_tgl, m_ack_tgl, m_link_sel, m_scan_en, m_native_en})
   );

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         m_rx_tgl_d_reg  <= 1'b0;
         m_ack_tgl_d_reg <= 1'b0;
      end
      else
      begin
         m_rx_tgl_d_reg  <= m_rx_tgl;
         m_ack_tgl_d_reg <= m_ack_tgl;
      end
   end

   // -----------------------------------------------------------------
   // mclk domain: mode selection
   // -----------------------------------------------------------------
   jpdlc_pkg::jpdlc_mode_e mode_reg;
   jpdlc_pkg::jpdlc_mode_e mode_next;
   logic mode_entry;
   logic scan_evt;
   logic scan_rx;
   logic scan_exc;
   logic native_rx;
   logic native_exc;
   logic abort_any;
   logic good_byte;
   logic [7:0] good_data;
   logic err_reg;
   logic tx_pend_reg;
   logic [jpdlc_pkg::KEY_W-1:0] key_sr_reg;
   logic [3:0] key_cnt_reg;
   logic nvm_ok;

   always_comb
   begin
      if (m_native_en)
         mode_next = jpdlc_pkg::LM_NATIVE; // RULE_15
      else if (m_scan_en && m_link_sel)
         mode_next = jpdlc_pkg::LM_SCAN;
      else
         mode_next = jpdlc_pkg::LM_OFF;
   end

   assign mode_entry = (mode_next != mode_reg) && (mode_next != jpdlc_pkg::LM_OFF);

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         mode_reg        <= jpdlc_pkg::LM_OFF;
         native_selected <= 1'b0;
         scan_selected   <= 1'b0;
      end
      else
      begin
         mode_reg        <= mode_next;
         native_selected <= (mode_next == jpdlc_pkg::LM_NATIVE); // RULE_15
         scan_selected   <= (mode_next == jpdlc_pkg::LM_SCAN);
      end
   end

   // -----------------------------------------------------------------
   // mclk domain: exceptions and error state
   // -----------------------------------------------------------------
   // held frame fields are read only after the toggle edge, so they are stable
   assign scan_evt   = (m_rx_tgl != m_rx_tgl_d_reg) && (mode_reg == jpdlc_pkg::LM_SCAN);
   assign scan_exc   = scan_evt && t_rx_perr_reg; // RULE_20 RULE_21
   assign scan_rx    = scan_evt && !t_rx_perr_reg && !tx_mode_reg; // RULE_05
   assign native_rx  = native_rx_valid && (mode_reg == jpdlc_pkg::LM_NATIVE) && !tx_mode_reg;
   assign native_exc = (mode_reg == jpdlc_pkg::LM_NATIVE) &&
                       (tx_mode_reg ? native_collision // RULE_21
                                    : (native_parity_err || native_frame_err ||
                                       native_abort)); // RULE_20
   assign abort_any  = (scan_evt && t_rx_abort_reg) ||
                       ((mode_reg == jpdlc_pkg::LM_NATIVE) && native_abort); // RULE_02
   assign good_byte  = (scan_rx || native_rx) && !err_reg; // RULE_23
   assign good_data  = scan_rx ? t_rx_data_reg : native_rx_data;

   // abort wins over the exception it also raises
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         err_reg <= 1'b0;
      else if (mode_entry || abort_any)
         err_reg <= 1'b0; // RULE_22 RULE_15
      else if (scan_exc || native_exc)
         err_reg <= 1'b1; // RULE_22
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
         tx_mode_reg <= 1'b0;
      else if (mode_entry || abort_any || scan_exc || native_exc)
         tx_mode_reg <= 1'b0; // RULE_22 RULE_02
      else if (rx_mode_req)
         tx_mode_reg <= 1'b0;
      else if (tx_mode_req && !err_reg)
         tx_mode_reg <= 1'b1; // RULE_05
   end

   // -----------------------------------------------------------------
   // mclk domain: transmit hand-off
   // -----------------------------------------------------------------
   // one byte in flight; the tck side acknowledges at capture
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         tx_pend_reg   <= 1'b0;
         m_req_tgl_reg <= 1'b0;
         tx_ready      <= 1'b0;
      end
      else
      begin
         if (m_ack_tgl != m_ack_tgl_d_reg)
            tx_pend_reg <= 1'b0;
         else if (tx_valid && tx_ready)
         begin
            tx_pend_reg   <= 1'b1;
            m_req_tgl_reg <= ~m_req_tgl_reg; // RULE_08
         end
         tx_ready <= !tx_pend_reg && !(tx_valid && tx_ready) && tx_mode_reg &&
                     !err_reg && (mode_reg == jpdlc_pkg::LM_SCAN);
      end
   end

   // -----------------------------------------------------------------
   // mclk domain: received bytes and key
   // -----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rx_valid   <= 1'b0;
         rx_data    <= '0;
         abort_seen <= 1'b0;
      end
      else
      begin
         rx_valid   <= good_byte;
         abort_seen <= abort_any;
         if (good_byte)
            rx_data <= good_data;
      end
   end

   // key bytes arrive least significant byte first
   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         key_sr_reg   <= '0;
         key_cnt_reg  <= '0;
         nvm_unlocked <= 1'b0;
      end
      else if (mode_entry)
      begin
         key_cnt_reg  <= '0;
         nvm_unlocked <= 1'b0; // RULE_17
      end
      else if (!key_capture)
         key_cnt_reg <= '0;
      else if (good_byte)
      begin
         key_sr_reg <= {good_data, key_sr_reg[jpdlc_pkg::KEY_W-1:jpdlc_pkg::DATA_W]};
         if (key_cnt_reg == jpdlc_pkg::KEY_BYTES - 4'h1)
         begin
            key_cnt_reg  <= '0;
            nvm_unlocked <= ({good_data, key_sr_reg[jpdlc_pkg::KEY_W-1:jpdlc_pkg::DATA_W]}
                             == jpdlc_pkg::UNLOCK_KEY); // RULE_18
         end
         else
            key_cnt_reg <= key_cnt_reg + 4'h1;
      end
   end

   // -----------------------------------------------------------------
   // mclk domain: internal access bus gate
   // -----------------------------------------------------------------
   // memory reads and writes go straight through; no data or address
   // register of the memory controller is touched on the way
   assign nvm_ok = nvm_unlocked && nvm_ctrl_enabled && nvm_prog_mode; // RULE_19

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         bus_req_out <= 1'b0;
         bus_nvm_out <= 1'b0;
         bus_refused <= 1'b0;
         link_error  <= 1'b0;
         tx_mode     <= 1'b0;
      end
      else
      begin
         bus_req_out <= bus_req && !err_reg && (mode_reg != jpdlc_pkg::LM_OFF) &&
                        (!bus_nvm || nvm_ok); // RULE_17 RULE_23
         bus_nvm_out <= bus_nvm;
         bus_refused <= bus_req && (err_reg || (mode_reg == jpdlc_pkg::LM_OFF) ||
                        (bus_nvm && !nvm_ok)); // RULE_17
         link_error  <= err_reg;
         tx_mode     <= tx_mode_reg;
      end
   end

endmodule : jpdlc_top

`default_nettype wire

// [jpdlc_monitor.sv]
// checker for the scan-link access controller, mclk domain outputs
// assumes it is bound onto jpdlc_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// checker
// ----------------------------------------------------------------
module jpdlc_monitor (
   // system
   input wire logic mclk, arst_n,
   // controller status
   input wire logic rx_valid, link_error, abort_seen, tx_mode,
   input wire logic native_selected, scan_selected, nvm_unlocked,
   // native phy events
   input wire logic native_parity_err, native_abort,
   // access bus gate
   input wire logic bus_req, bus_nvm, nvm_ctrl_enabled, nvm_prog_mode,
   input wire logic bus_req_out, bus_nvm_out, bus_refused
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   err_no_rx_a: assert property ($past(link_error) && link_error |-> !rx_valid)
      else $error("rx_valid raised in error state");
   bus_refuse_a: assert property ($past(bus_req) && $past(link_error)
      |-> bus_refused && !bus_req_out) else $error("bus passed in error state");
   bus_pass_a: assert property (bus_req_out |-> $past(bus_req) && !$past(link_error))
      else $error("bus passed without request");
   nvm_gate_a: assert property (bus_req_out && bus_nvm_out |-> $past(nvm_unlocked)
      && $past(nvm_ctrl_enabled) && $past(nvm_prog_mode)) else $error("memory gate open");
   abort_clr_a: assert property (abort_seen |-> ##[0:2] (!link_error && !tx_mode))
      else $error("abort left error or tx mode");
   rx_pulse_a: assert property (rx_valid |=> !rx_valid)
      else $error("rx_valid longer than one cycle");
   one_layer_a: assert property (!(native_selected && scan_selected))
      else $error("both link layers selected");
   native_exc_a: assert property (native_parity_err && native_selected && !tx_mode
      && !native_abort |-> ##[1:3] link_error) else $error("native parity error ignored");
   native_abt_a: assert property (native_abort && native_selected
      |-> ##[1:3] !link_error) else $error("native abort did not clear error");
endmodule : jpdlc_monitor

bind jpdlc_top jpdlc_monitor mon_u (.*);
`default_nettype wire

// [jpdlc_prog_model.sv]
// programmer model: drives tck, tms and tdi, samples tdo
// assumes tck stands still low between calls, 80 ns period
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// programmer
// ----------------------------------------------------------------
module jpdlc_prog_model (
   // scan port
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   initial {tck, tms, tdi} = 3'b010;
   // change on falling tck, sample on rising
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #40 tck = 1'b1;
      o = tdo;
      #40 tck = 1'b0;
   endtask : step
   // tdi toggles outside shifts so a stale level never looks valid
   task automatic path(input logic [3:0] m, input int n);
      logic o;
      for (int i = 0; i < n; i++) step(m[i], ~tdi, o);
   endtask : path
   task automatic tap_reset;
      path(4'hf, 4);
      path(4'h1, 2);
   endtask : tap_reset
   task automatic load_ir(input logic [3:0] c);
      logic o;
      path(4'h3, 4);
      for (int i = 0; i < 4; i++) step(i == 3, c[i], o);
      path(4'h1, 2);
   endtask : load_ir
   // data lsb first then parity; a wait answer is simply clocked again
   task automatic frame(input logic [8:0] d, output logic [8:0] q);
      path(4'h1, 3);
      for (int i = 0; i < 9; i++) step(i == 8, d[i], q[i]);
      path(4'h1, 2);
   endtask : frame
endmodule : jpdlc_prog_model
`default_nettype wire

// [tb_jtag_program_debug_link_controller.sv]
// self-checking bench for the scan-link access controller
// assumes the programmer model owns tck; mclk period 40 ns
`timescale 1ns/1ps
`default_nettype none
module tb_jtag_program_debug_link_controller;
   logic mclk = 1'b0, arst_n = 1'b0, tck, tms, tdi, tdo, tdo_oe, tx_ready, rx_valid, tx_valid;
   logic scan_port_enable, native_link_enable, native_parity_err, native_abort, tx_mode_req;
   logic rx_mode_req, key_capture, abort_seen, bus_req, bus_nvm, nvm_ctrl_enabled;
   logic nvm_prog_mode, link_error, tx_mode, native_selected, scan_selected, nvm_unlocked;
   logic bus_req_out, bus_nvm_out, bus_refused;
   logic [7:0] tx_data, rx_data, b;
   logic [8:0] q;
   logic [63:0] key;
   logic [7:0] got[$], exp[$];
   int err_total = 0, num_checks = 0, cyc = 0, seed = 43, aborts = 0;
   localparam logic [8:0] IDLE = {1'b1, jpdlc_pkg::CHR_IDLE};
   localparam logic [8:0] DLY = {1'b1, jpdlc_pkg::CHR_WAIT}, ABT = {1'b1, jpdlc_pkg::CHR_ABORT};
   jpdlc_prog_model m (.*);
   jpdlc_top dut_u (.*, .native_rx_valid(1'b0), .native_rx_data(8'h00),
      .native_frame_err(1'b0), .native_collision(1'b0));
   initial forever #20 mclk = ~mclk;
   task automatic w(input int n);
      repeat (n) @(negedge mclk);
   endtask : w
   task automatic close_out;
      if (err_total == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : close_out
   task automatic chk_frame(input logic [8:0] g, input logic [8:0] e);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %0t frame %h expected %h", $time, g, e);
      end
   endtask : chk_frame
   task automatic chk_flag(input logic g, input logic e);
      num_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("Error %0t flag %b expected %b", $time, g, e);
      end
   endtask : chk_flag
   task automatic send(input logic [8:0] d, input logic [8:0] e);
      m.frame(d, q);
      chk_frame(q, e);
      w(8);
   endtask : send
   task automatic put(input logic [7:0] d);
      exp.push_back(d);
      send({^d, d}, IDLE);
   endtask : put
   task automatic bus_try(input logic e);
      bus_req = 1'b1;
      w(2);
      chk_flag(bus_req_out, e);
      chk_flag(bus_refused, ~e);
      chk_flag(bus_nvm_out, bus_nvm);
      bus_req = 1'b0;
   endtask : bus_try
   // reference model: each good byte shows up once, in order
   always @(posedge mclk)
   begin
      cyc++;
      if (rx_valid === 1'b1) got.push_back(rx_data);
      if (abort_seen === 1'b1) aborts++;
      if (cyc == 20000)
      begin
         err_total++;
         close_out();
      end
   end
   initial
   begin
      {scan_port_enable, native_link_enable, native_parity_err, native_abort} = '0;
      {tx_mode_req, rx_mode_req, tx_valid, key_capture, bus_req, bus_nvm} = '0;
      {nvm_ctrl_enabled, nvm_prog_mode, tx_data} = '0;
      w(12);
      arst_n = 1'b1;
      scan_port_enable = 1'b1;
      w(4);
      m.tap_reset();
      m.load_ir(4'h7);
      w(8);
      chk_flag(scan_selected, 1'b1);
      chk_flag(tdo_oe, 1'b0);
      for (int i = 0; i < 6; i++) put(8'($random(seed)));
      send({1'b1, 8'h5a}, IDLE);
      chk_flag(link_error, 1'b1);
      send({1'b0, 8'h5a}, IDLE);
      bus_try(1'b0);
      send(ABT, IDLE);
      chk_flag(link_error | (aborts != 1), 1'b0);
      tx_mode_req = 1'b1;
      @(negedge mclk) tx_mode_req = 1'b0;
      w(4);
      send({1'b0, 8'h5a}, DLY);
      b = 8'($random(seed));
      tx_data = b;
      tx_valid = 1'b1;
      for (int i = 0; i < 20 && tx_ready !== 1'b1; i++) @(negedge mclk);
      @(negedge mclk) tx_valid = 1'b0;
      w(4);
      send({1'b0, 8'h5a}, {^b, b});
      send({1'b1, 8'h5a}, DLY);
      chk_flag(link_error, 1'b1);
      send(ABT, IDLE);
      {bus_nvm, nvm_ctrl_enabled, nvm_prog_mode} = 3'h7;
      bus_try(1'b0);
      for (int k = 0; k < 2; k++)
      begin
         key = jpdlc_pkg::UNLOCK_KEY ^ 64'(k == 0);
         key_capture = 1'b1;
         for (int i = 0; i < 8; i++) put(key[8*i+:8]);
         key_capture = 1'b0;
         w(4);
         chk_flag(nvm_unlocked, k == 1);
         bus_try(k == 1);
      end
      nvm_prog_mode = 1'b0;
      bus_try(1'b0);
      native_link_enable = 1'b1;
      w(8);
      chk_flag(native_selected & ~scan_selected & ~nvm_unlocked, 1'b1);
      native_parity_err = 1'b1;
      @(negedge mclk) native_parity_err = 1'b0;
      w(4);
      chk_flag(link_error, 1'b1);
      native_abort = 1'b1;
      @(negedge mclk) native_abort = 1'b0;
      w(4);
      chk_flag(link_error, 1'b0);
      chk_frame(9'(got.size()), 9'(exp.size()));
      while (got.size() > 0 && exp.size() > 0)
         chk_frame({1'b0, got.pop_front()}, {1'b0, exp.pop_front()});
      close_out();
   end
endmodule : tb_jtag_program_debug_link_controller
`default_nettype wire
